// file: common/ndc_defs.svh
// Constants of the network drive command handler: offsets, fields, resets, limits.
// Assumes inclusion by bare name from the design and checker files.
`ifndef NDC_DEFS_SVH
`define NDC_DEFS_SVH
`define NDC_BIT_FWD        0
`define NDC_BIT_REV        1
`define NDC_BIT_NET_RUN    5
`define NDC_BIT_NET_REF    6
`define NDC_POLL_BYTES     8
`define NDC_FREQ_MAX       16'd36000
`define NDC_RAMP_MIN       16'd1
`define NDC_RAMP_MAX       16'd30000
`define NDC_NODE_MAX       6'd63
`define NDC_NODE_RST       6'd63
`define NDC_EXPL_CLASS     16'd100
`define NDC_EXPL_INST      16'd1
`define NDC_EXPL_ATTR_FREQ 8'd159
`define NDC_OFF_FREQ       12'h000
`define NDC_OFF_ACCEL      12'h004
`define NDC_OFF_DECEL      12'h008
`define NDC_OFF_NODE       12'h00c
`define NDC_OFF_INCH       12'h010
`define NDC_OFF_RAMP2      12'h014
`define NDC_OFF_STATUS     12'h018
`define NDC_OFF_SCANS      12'h01c
`define NDC_FREQ_RST       16'd1500
`define NDC_ACCEL_RST      16'd100
`define NDC_DECEL_RST      16'd100
`define NDC_INCH_RST       16'd500
`define NDC_RAMP2_RST      32'h0064_0064
`endif

// file: common/ndc_pkg.sv
// Types shared by the command handler files.
// Assumes ndc_defs.svh on the include path.
package ndc_pkg;
  typedef struct packed {
    logic [15:0] w3;
    logic [15:0] w2;
    logic [15:0] w1;
    logic [15:0] w0;
  } ndc_poll_t;

  typedef struct packed {
    logic [5:0]  node;
    logic [15:0] cls;
    logic [15:0] inst;
    logic [7:0]  attr;
    logic        is_set;
    logic [15:0] wdata;
  } ndc_expl_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        err;
  } ndc_expl_rsp_t;

  typedef enum logic [2:0] {
    NDC_STOP = 3'b001,
    NDC_FWD  = 3'b010,
    NDC_REV  = 3'b100
  } ndc_run_t;
endpackage : ndc_pkg

// file: design/ndc_word_rx.sv
// Assembles one polled scan of eight bytes into four words.
// Assumes bytes come on pclk from the network controller, frame_start before byte 0.
`timescale 1ns/1ns
`include "ndc_defs.svh"
module ndc_word_rx #(
  parameter int NBYTES = `NDC_POLL_BYTES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              frame_start,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  output ndc_pkg::ndc_poll_t     poll,
  output logic                   scan_done
);
  logic [NBYTES*8-1:0] shift_r;
  logic [3:0]          cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= '0;
      cnt_r   <= 4'h0;
    end else if (frame_start) begin
      cnt_r <= 4'h0;
    end else if (byte_valid && cnt_r < 4'(NBYTES)) begin
      shift_r <= {byte_data, shift_r[NBYTES*8-1:8]};
      cnt_r   <= cnt_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_done <= 1'b0;
      poll      <= '0;
    end else begin
      scan_done <= byte_valid && !frame_start && cnt_r == 4'(NBYTES - 1);
      if (byte_valid && !frame_start && cnt_r == 4'(NBYTES - 1)) begin
        poll <= {byte_data, shift_r[NBYTES*8-1:8]};
      end
    end
  end
endmodule : ndc_word_rx

// file: design/ndc_range_gate.sv
// Holds one network reference, taking a new value only when inside limits.
// Assumes a one-cycle load strobe; only reset drops back to the not-supplied state.
`timescale 1ns/1ns
module ndc_range_gate #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] value,
  output logic [15:0]      held,
  output logic             supplied
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held     <= 16'h0000;
      supplied <= 1'b0;
    end else if (load && value >= LO && value <= HI) begin
      held     <= value;
      supplied <= 1'b1;
    end
  end
endmodule : ndc_range_gate

// file: design/ndc_top.sv
// Network drive command handler: polled word interpreter, run sequencing, explicit get (sets refused), APB registers.
// Assumes network controller on pclk delivering bytes and explicit requests; terminals are raw pins.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "ndc_defs.svh"
module ndc_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  poll_frame_start,
  input  wire logic                  poll_byte_valid,
  input  wire logic [7:0]            poll_byte,
  input  wire logic                  expl_req_valid,
  input  wire ndc_pkg::ndc_expl_req_t expl_req,
  output logic                       expl_rsp_valid,
  output ndc_pkg::ndc_expl_rsp_t     expl_rsp,
  input  wire logic                  local_halt_terminal,
  input  wire logic                  multispeed_select_terminal_1,
  input  wire logic                  multispeed_select_terminal_2,
  input  wire logic                  multispeed_select_terminal_3,
  input  wire logic                  multispeed_select_terminal_4,
  input  wire logic                  inch_terminal,
  input  wire logic                  second_ramp_terminal,
  output logic                       motor_run,
  output logic                       motor_reverse,
  output logic [15:0]                freq_cmd,
  output logic [15:0]                accel_cmd,
  output logic [15:0]                decel_cmd,
  output logic [3:0]                 multispeed_code,
  output logic                       multispeed_active,
  output logic                       net_run_source,
  output logic                       net_ref_source,
  output logic                       run_key_led
);
  // Polled scan assembly
  ndc_pkg::ndc_poll_t poll;
  logic               scan_done;

  ndc_word_rx #(
    .NBYTES (`NDC_POLL_BYTES)
  ) u_rx (
    .pclk        (pclk),
    .presetn     (presetn),
    .frame_start (poll_frame_start),
    .byte_valid  (poll_byte_valid),
    .byte_data   (poll_byte),
    .poll        (poll),
    .scan_done   (scan_done)
  );

  // Network references, scaled as the stored profile values
  logic [15:0] net_freq;
  logic [15:0] net_accel;
  logic [15:0] net_decel;
  logic        net_freq_ok;
  logic        net_accel_ok;
  logic        net_decel_ok;

  ndc_range_gate #(
    .LO (16'h0000),
    .HI (`NDC_FREQ_MAX)
  ) u_freq (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (scan_done),
    .value    (poll.w1),
    .held     (net_freq),
    .supplied (net_freq_ok)
  );

  ndc_range_gate #(
    .LO (`NDC_RAMP_MIN),
    .HI (`NDC_RAMP_MAX)
  ) u_accel (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (scan_done),
    .value    (poll.w2),
    .held     (net_accel),
    .supplied (net_accel_ok)
  );

  ndc_range_gate #(
    .LO (`NDC_RAMP_MIN),
    .HI (`NDC_RAMP_MAX)
  ) u_decel (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (scan_done),
    .value    (poll.w3),
    .held     (net_decel),
    .supplied (net_decel_ok)
  );

  // Terminal synchronisers; first stage feeds only the second
  logic [6:0] term_s1_r;
  logic [6:0] term_s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_s1_r <= 7'h00;
      term_s2_r <= 7'h00;
    end else begin
      term_s1_r <= {second_ramp_terminal, inch_terminal, local_halt_terminal,
                    multispeed_select_terminal_4, multispeed_select_terminal_3,
                    multispeed_select_terminal_2, multispeed_select_terminal_1};
      term_s2_r <= term_s1_r;
    end
  end

  logic [3:0] ms_code;
  logic       halt_in;
  logic       inch_in;
  logic       ramp2_in;
  assign ms_code  = term_s2_r[3:0];
  assign halt_in  = term_s2_r[4];
  assign inch_in  = term_s2_r[5];
  assign ramp2_in = term_s2_r[6];

  // Stored profile and configuration
  logic [15:0] freq_r;
  logic [15:0] accel_r;
  logic [15:0] decel_r;
  logic [5:0]  node_r;
  logic [15:0] inch_freq_r;
  logic [31:0] ramp2_r;
  logic [31:0] scans_r;

  logic        apb_wr;
  logic        apb_rd;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_r      <= `NDC_FREQ_RST;
      accel_r     <= `NDC_ACCEL_RST;
      decel_r     <= `NDC_DECEL_RST;
      node_r      <= `NDC_NODE_RST;
      inch_freq_r <= `NDC_INCH_RST;
      ramp2_r     <= `NDC_RAMP2_RST;
    end else if (apb_wr) begin
      case (paddr)
        `NDC_OFF_FREQ: begin
          if (pwdata[15:0] <= `NDC_FREQ_MAX) freq_r <= pwdata[15:0];
        end
        `NDC_OFF_ACCEL: begin
          if (pwdata[15:0] >= `NDC_RAMP_MIN && pwdata[15:0] <= `NDC_RAMP_MAX) accel_r <= pwdata[15:0];
        end
        `NDC_OFF_DECEL: begin
          if (pwdata[15:0] >= `NDC_RAMP_MIN && pwdata[15:0] <= `NDC_RAMP_MAX) decel_r <= pwdata[15:0];
        end
        `NDC_OFF_NODE: begin
          if (pwdata[5:0] <= `NDC_NODE_MAX) node_r <= pwdata[5:0];
        end
        `NDC_OFF_INCH: begin
          if (pwdata[15:0] <= `NDC_FREQ_MAX) inch_freq_r <= pwdata[15:0];
        end
        `NDC_OFF_RAMP2: begin
          ramp2_r <= pwdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scans_r <= 32'h0000_0000;
    end else if (scan_done) begin
      scans_r <= scans_r + 32'h0000_0001;
    end
  end

  // Source selection bits, frozen while rotating
  ndc_pkg::ndc_run_t run_r;
  ndc_pkg::ndc_run_t run_nxt;
  logic              src_run_r;
  logic              src_ref_r;
  logic              fwd_prev_r;
  logic              rev_prev_r;
  logic              fwd_bit;
  logic              rev_bit;
  logic              fwd_rise;
  logic              rev_rise;

  assign fwd_bit  = poll.w0[`NDC_BIT_FWD];
  assign rev_bit  = poll.w0[`NDC_BIT_REV];
  assign fwd_rise = scan_done && fwd_bit && !fwd_prev_r;
  assign rev_rise = scan_done && rev_bit && !rev_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_run_r <= 1'b0;
      src_ref_r <= 1'b0;
    end else if (scan_done && run_r == ndc_pkg::NDC_STOP) begin
      src_run_r <= poll.w0[`NDC_BIT_NET_RUN];
      src_ref_r <= poll.w0[`NDC_BIT_NET_REF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_prev_r <= 1'b0;
      rev_prev_r <= 1'b0;
    end else if (scan_done) begin
      fwd_prev_r <= fwd_bit;
      rev_prev_r <= rev_bit;
    end
  end

  // Run sequencing; a run bit already high when control is taken needs a fresh edge
  always_comb begin
    run_nxt = run_r;
    case (run_r)
      ndc_pkg::NDC_STOP: begin
        if (src_run_r && !halt_in) begin
          if (fwd_rise && !rev_bit) begin
            run_nxt = ndc_pkg::NDC_FWD;
          end else if (rev_rise && !fwd_bit) begin
            run_nxt = ndc_pkg::NDC_REV;
          end
        end
      end
      ndc_pkg::NDC_FWD: begin
        if (halt_in || (scan_done && !fwd_bit)) run_nxt = ndc_pkg::NDC_STOP;
      end
      ndc_pkg::NDC_REV: begin
        if (halt_in || (scan_done && !rev_bit)) run_nxt = ndc_pkg::NDC_STOP;
      end
      default: begin
        run_nxt = ndc_pkg::NDC_STOP;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= ndc_pkg::NDC_STOP;
    end else begin
      run_r <= run_nxt;
    end
  end

  // Reference selection; terminals first, then network, then stored profile
  logic [15:0] freq_sel;
  logic [15:0] accel_sel;
  logic [15:0] decel_sel;

  always_comb begin
    freq_sel  = (src_ref_r && net_freq_ok) ? net_freq : freq_r;
    accel_sel = (src_ref_r && net_accel_ok) ? net_accel : accel_r;
    decel_sel = (src_ref_r && net_decel_ok) ? net_decel : decel_r;
    if (inch_in) begin
      freq_sel = inch_freq_r;
    end
    if (ramp2_in) begin
      accel_sel = ramp2_r[15:0];
      decel_sel = ramp2_r[31:16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_run         <= 1'b0;
      motor_reverse     <= 1'b0;
      freq_cmd          <= `NDC_FREQ_RST;
      accel_cmd         <= `NDC_ACCEL_RST;
      decel_cmd         <= `NDC_DECEL_RST;
      multispeed_code   <= 4'h0;
      multispeed_active <= 1'b0;
      net_run_source    <= 1'b0;
      net_ref_source    <= 1'b0;
      run_key_led       <= 1'b1;
    end else begin
      motor_run         <= run_r != ndc_pkg::NDC_STOP;
      motor_reverse     <= run_r == ndc_pkg::NDC_REV;
      freq_cmd          <= freq_sel;
      accel_cmd         <= accel_sel;
      decel_cmd         <= decel_sel;
      multispeed_code   <= ms_code;
      multispeed_active <= ms_code != 4'h0;
      net_run_source    <= src_run_r;
      net_ref_source    <= src_ref_r;
      run_key_led       <= !src_run_r && !src_ref_r;
    end
  end

  // Explicit messaging, served beside the polled path
  logic addr_ok;
  logic hit_freq;
  assign addr_ok  = expl_req.node == node_r && expl_req.cls != 16'h0000
                    && expl_req.attr != 8'h00;
  assign hit_freq = expl_req.cls == `NDC_EXPL_CLASS && expl_req.inst == `NDC_EXPL_INST
                    && expl_req.attr == `NDC_EXPL_ATTR_FREQ;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expl_rsp_valid <= 1'b0;
      expl_rsp       <= '0;
    end else begin
      expl_rsp_valid <= expl_req_valid && addr_ok;
      if (expl_req_valid && addr_ok) begin
        if (hit_freq && !expl_req.is_set) begin
          expl_rsp.rdata <= freq_r;
          expl_rsp.err   <= 1'b0;
        end else begin
          // Frequency attribute is get-only; no settable attribute exists here
          expl_rsp.rdata <= 16'h0000;
          expl_rsp.err   <= 1'b1;
        end
      end
    end
  end

  // APB slave, zero wait states
  logic [31:0] rd_mux;
  logic        map_hit;

  always_comb begin
    rd_mux  = 32'h0000_0000;
    map_hit = 1'b1;
    case (paddr)
      `NDC_OFF_FREQ:   rd_mux = {16'h0000, freq_r};
      `NDC_OFF_ACCEL:  rd_mux = {16'h0000, accel_r};
      `NDC_OFF_DECEL:  rd_mux = {16'h0000, decel_r};
      `NDC_OFF_NODE:   rd_mux = {26'h000_0000, node_r};
      `NDC_OFF_INCH:   rd_mux = {16'h0000, inch_freq_r};
      `NDC_OFF_RAMP2:  rd_mux = ramp2_r;
      `NDC_OFF_STATUS: rd_mux = {24'h00_0000, ms_code, run_r == ndc_pkg::NDC_REV,
                                 run_r != ndc_pkg::NDC_STOP, src_ref_r, src_run_r};
      `NDC_OFF_SCANS:  rd_mux = scans_r;
      default:         map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule : ndc_top

// file: verif/ndc_top_assertions.sv
// Concurrent checks on the command handler's top-level ports.
// Assumes ndc_pkg compiled first and ndc_defs.svh on the include path; bound from the bench.
`timescale 1ns/1ns
`include "ndc_defs.svh"
module ndc_top_assertions (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   expl_req_valid,
  input wire ndc_pkg::ndc_expl_req_t expl_req,
  input wire logic                   expl_rsp_valid,
  input wire ndc_pkg::ndc_expl_rsp_t expl_rsp,
  input wire logic                   motor_run,
  input wire logic                   motor_reverse,
  input wire logic                   net_run_source,
  input wire logic                   net_ref_source,
  input wire logic                   run_key_led,
  input wire logic [15:0]            freq_cmd,
  input wire logic [15:0]            accel_cmd,
  input wire logic [15:0]            decel_cmd,
  input wire logic [3:0]             multispeed_code,
  input wire logic                   multispeed_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_run_needs_src:
    assert property ($rose(motor_run) |-> net_run_source) else $error("motor started without network run");
  a_src_frozen:
    assert property (motor_run && $past(motor_run) |-> $stable(net_run_source) && $stable(net_ref_source))
    else $error("source bits changed while running");
  a_led_local:
    assert property (!net_run_source && !net_ref_source && $past(!net_run_source && !net_ref_source) |-> run_key_led)
    else $error("run key indicator dark under local control");
  a_led_net:
    assert property (net_run_source && $past(net_run_source) |-> !run_key_led) else $error("indicator lit under network");
  a_freq_limit:
    assert property (freq_cmd <= `NDC_FREQ_MAX) else $error("frequency command above limit");
  a_ramp_limit:
    assert property (accel_cmd >= `NDC_RAMP_MIN && accel_cmd <= `NDC_RAMP_MAX && decel_cmd >= `NDC_RAMP_MIN
                     && decel_cmd <= `NDC_RAMP_MAX) else $error("ramp command outside limits");
  a_ms_flag:
    assert property (multispeed_active == (multispeed_code != 4'h0)) else $error("multispeed flag disagrees with code");
  a_rsp_cause:
    assert property (expl_rsp_valid |-> $past(expl_req_valid)) else $error("answer without request");
  a_get_freq:
    assert property (expl_rsp_valid && $past(expl_req_valid && !expl_req.is_set && expl_req.cls == `NDC_EXPL_CLASS
                     && expl_req.inst == `NDC_EXPL_INST && expl_req.attr == `NDC_EXPL_ATTR_FREQ) |-> !expl_rsp.err)
    else $error("frequency get refused");
  a_set_refused:
    assert property (expl_rsp_valid && $past(expl_req_valid && expl_req.is_set) |-> expl_rsp.err
                     && expl_rsp.rdata == 16'h0000) else $error("set on get-only attribute accepted");
  a_attr_zero:
    assert property (expl_req_valid && expl_req.attr == 8'h00 |=> !expl_rsp_valid) else $error("attribute zero answered");

  c_rev_run: cover property (motor_run && motor_reverse);
  c_get_ok: cover property (expl_rsp_valid && !expl_rsp.err);
  c_ms: cover property (multispeed_active);
endmodule : ndc_top_assertions

// file: verif/ndc_host_model.sv
// Network master model: polled scans and explicit requests.
// Assumes the bench calls its tasks; drives only after rising edges.
`timescale 1ns/1ns
module ndc_host_model (
  input  wire logic              pclk,
  output logic                   poll_frame_start,
  output logic                   poll_byte_valid,
  output logic [7:0]             poll_byte,
  output logic                   expl_req_valid,
  output ndc_pkg::ndc_expl_req_t expl_req
);
  initial begin
    poll_frame_start = 1'b0;
    poll_byte_valid = 1'b0;
    poll_byte = 8'h00;
    expl_req_valid = 1'b0;
    expl_req = '0;
  end

  // Gap slows the scan; released byte lines show the inverse, never a stale value
  task automatic scan(input logic [15:0] w0, w1, w2, w3, input int gap);
    logic [63:0] f;
    f = {w3, w2, w1, w0};
    @(posedge pclk);
    poll_frame_start <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      poll_frame_start <= 1'b0;
      poll_byte_valid <= 1'b1;
      poll_byte <= f[8*i +: 8];
      repeat (gap) begin
        @(posedge pclk);
        poll_byte_valid <= 1'b0;
        poll_byte <= ~f[8*i +: 8];
      end
    end
    @(posedge pclk);
    poll_byte_valid <= 1'b0;
    poll_byte <= ~f[63:56];
  endtask : scan

  // Instance fixed at 1; the bench picks node, attribute and direction
  task automatic expl(input logic [5:0] node, input logic [15:0] cls, input logic [7:0] attr, input logic st);
    logic [62:0] r;
    r = {node, cls, 16'h0001, attr, st, 16'h1234};
    @(posedge pclk);
    expl_req_valid <= 1'b1;
    expl_req <= r;
    @(posedge pclk);
    expl_req_valid <= 1'b0;
    expl_req <= ~r;
  endtask : expl

  function automatic logic [15:0] to_hz(input logic [15:0] raw);
    return raw / 16'd100;
  endfunction : to_hz
endmodule : ndc_host_model

// file: verif/ndc_top_tb.sv
// Self-checking bench for ndc_top: APB register tasks, host model scans, terminal pins.
// Assumes design, package and checker compiled before this file.
`timescale 1ns/1ns
module ndc_top_tb;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0, prdata, rd;
  logic                   pready, pslverr, er;
  logic                   pfs, pbv, erv, ersv, motor_run, motor_reverse, net_run, net_ref, led, ms_act;
  logic [7:0]             pb;
  ndc_pkg::ndc_expl_req_t ereq;
  ndc_pkg::ndc_expl_rsp_t ersp;
  logic                   halt = 1'b0, inch = 1'b0, ramp2 = 1'b0;
  logic [3:0]             ms_t = 4'h0, ms_code;
  logic [15:0]            freq_cmd, accel_cmd, decel_cmd;
  int                     miscompares = 0, n_compared = 0, cycles = 0, nscans = 0;
  logic [11:0]            ra [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
  logic [31:0]            rv [7] = '{32'h5dc, 32'h64, 32'h64, 32'h3f, 32'h1f4, 32'h0064_0064, 32'h0};

  always #2 pclk = ~pclk;

  ndc_host_model host (.pclk(pclk), .poll_frame_start(pfs), .poll_byte_valid(pbv), .poll_byte(pb),
    .expl_req_valid(erv), .expl_req(ereq));

  ndc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .poll_frame_start(pfs),
    .poll_byte_valid(pbv), .poll_byte(pb), .expl_req_valid(erv), .expl_req(ereq), .expl_rsp_valid(ersv),
    .expl_rsp(ersp), .local_halt_terminal(halt), .multispeed_select_terminal_1(ms_t[0]),
    .multispeed_select_terminal_2(ms_t[1]), .multispeed_select_terminal_3(ms_t[2]),
    .multispeed_select_terminal_4(ms_t[3]), .inch_terminal(inch), .second_ramp_terminal(ramp2),
    .motor_run(motor_run), .motor_reverse(motor_reverse), .freq_cmd(freq_cmd), .accel_cmd(accel_cmd),
    .decel_cmd(decel_cmd), .multispeed_code(ms_code), .multispeed_active(ms_act), .net_run_source(net_run),
    .net_ref_source(net_ref), .run_key_led(led));

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits on pready without assuming the slave's latency
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
  endtask : apb

  task expl(input logic [5:0] node, input logic [7:0] attr, input logic st, input logic ans,
            input logic [15:0] erd, input logic eerr);
    logic got;
    got = 1'b0;
    host.expl(node, 16'd100, attr, st);
    repeat (4) begin
      @(posedge pclk);
      if (ersv === 1'b1 && !got) begin
        got = 1'b1;
        chk(ersp.rdata, erd);
        chk(ersp.err, eerr);
      end
    end
    chk(got, ans);
  endtask : expl

  // Outputs settle about three edges after the last byte
  task scan(input logic [15:0] w0, w1, w2, w3, input int gap);
    host.scan(w0, w1, w2, w3, gap);
    repeat (5) @(posedge pclk);
    nscans++;
  endtask : scan

  task outs(input logic [15:0] f, a, d, input logic [3:0] st);
    chk(freq_cmd, f);
    chk({accel_cmd, decel_cmd}, {a, d});
    chk({motor_run, motor_reverse, net_run, net_ref}, st);
  endtask : outs

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    outs(16'd1500, 16'd100, 16'd100, 4'h0);
    chk(led, 1'b1);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(er, 1'b0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 12'h000, 32'h9c40);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h5dc);
    apb(1'b1, 12'h000, 32'h3e8);
    expl(6'd63, 8'd159, 1'b0, 1'b1, 16'h3e8, 1'b0);
    chk(host.to_hz(ersp.rdata), 32'd10);
    expl(6'd63, 8'd159, 1'b1, 1'b1, 16'h0, 1'b1);
    expl(6'd63, 8'd160, 1'b0, 1'b1, 16'h0, 1'b1);
    expl(6'd63, 8'd0, 1'b0, 1'b0, 16'h0, 1'b0);
    expl(6'd5, 8'd159, 1'b0, 1'b0, 16'h0, 1'b0);
    apb(1'b1, 12'h00c, 32'h5);
    expl(6'd5, 8'd159, 1'b0, 1'b1, 16'h3e8, 1'b0);
    expl(6'd63, 8'd159, 1'b0, 1'b0, 16'h0, 1'b0);
    scan(16'h0001, 16'd40000, 16'd0, 16'd0, 0);
    outs(16'd1000, 16'd100, 16'd100, 4'h0);
    scan(16'h0060, 16'd40000, 16'd0, 16'd0, 0);
    outs(16'd1000, 16'd100, 16'd100, 4'h3);
    chk(led, 1'b0);
    scan(16'h0061, 16'd2000, 16'd100, 16'd200, 2);
    outs(16'd2000, 16'd100, 16'd200, 4'hb);
    scan(16'h0001, 16'd40000, 16'd300, 16'd0, 0);
    outs(16'd2000, 16'd300, 16'd200, 4'hb);
    inch <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(freq_cmd, 16'd500);
    inch <= 1'b0;
    apb(1'b1, 12'h014, 32'h0096_0032);
    ramp2 <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({accel_cmd, decel_cmd}, {16'd50, 16'd150});
    ramp2 <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      ms_t <= 4'h1 << i;
      repeat (5) @(posedge pclk);
      chk({ms_act, ms_code}, {1'b1, 4'h1 << i});
    end
    ms_t <= 4'h0;
    scan(16'h0060, 16'd2000, 16'd300, 16'd200, 0);
    outs(16'd2000, 16'd300, 16'd200, 4'h3);
    scan(16'h0062, 16'd1500, 16'd300, 16'd200, 0);
    outs(16'd1500, 16'd300, 16'd200, 4'hf);
    scan(16'h0060, 16'd1500, 16'd300, 16'd200, 0);
    outs(16'd1500, 16'd300, 16'd200, 4'h3);
    scan(16'h0000, 16'd1500, 16'd300, 16'd200, 0);
    outs(16'd1000, 16'd100, 16'd100, 4'h0);
    chk(led, 1'b1);
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, nscans);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    outs(16'd1500, 16'd100, 16'd100, 4'h0);
    scan(16'h0060, 16'd2000, 16'd0, 16'd0, 0);
    scan(16'h0061, 16'd2000, 16'd0, 16'd0, 0);
    outs(16'd2000, 16'd100, 16'd100, 4'hb);
    end_sim();
  end
endmodule : ndc_top_tb

bind ndc_top ndc_top_assertions chk_i (.pclk, .presetn, .expl_req_valid, .expl_req, .expl_rsp_valid, .expl_rsp,
  .motor_run, .motor_reverse, .net_run_source, .net_ref_source, .run_key_led, .freq_cmd, .accel_cmd,
  .decel_cmd, .multispeed_code, .multispeed_active);
